// file: irb_consts.vh
// Constants for the infrared bit encoder/decoder.
// Assumes a single system clock and a UART baud tick one clock wide.
// What this block does
// - Receive pin synchronised to system clock first
// - Filter select 0 bypasses, 1 inserts filter
// - Half-duplex when enabled: never transmit and receive together
// - Timing taken from UART baud tick
// - One bit: output low whole period
// - Zero bit: low 7, high 3, low 6
// - Enabled: transmit pin carries modulated signal
// - Enabled: UART input fed demodulated data, held high while I_UART_TX_BUSY
// - Receive tick counter runs 0 to 15
// - Demodulated output lags counter reset nine ticks
// - Falling edge resets receive counter
// - Count 8 updates demodulated output
// - Count 12 opens pulse sampling window
`ifndef IRB_CONSTS_VH
`define IRB_CONSTS_VH
`define IRB_CNT_W 4
`define IRB_CNT_ZERO 4'h0
`define IRB_CNT_LAST 4'hf
`define IRB_PULSE_START 4'h7
`define IRB_PULSE_END 4'ha
`define IRB_UPDATE_CNT 4'h8
`define IRB_WINDOW_CNT 4'hc
`define IRB_FILT_W 2
`define IRB_FILT_MAX 2'h3
`define IRB_FILT_ZERO 2'h0
`endif

// file: irb_endec.v
// Infrared bit encoder/decoder between a UART and an infrared transceiver.
// Assumes I_BAUD_TICK is a one-cycle pulse at sixteen times the bit rate.
// Receive pulses from the transceiver are taken as active high.
`timescale 1ns/100ps
`include "irb_consts.vh"

module irb_endec
(
    input wire I_MCLK,
    input wire I_RESETN,
    input wire I_ENABLE,
    input wire I_BAUD_TICK,
    input wire I_NOISE_FILTER_SELECT,
    input wire I_UART_TXD,
    input wire I_UART_TX_BUSY,
    input wire I_MODULATED_RX_IN,
    output reg O_MODULATED_TX_OUT,
    output reg O_UART_RXD
);

    reg rst_meta;
    reg rst_sync;
    wire rst_n;
    reg rx_s1;
    reg rx_s2;
    reg rx_s3;
    reg rx_clean;
    reg [`IRB_FILT_W-1:0] filt_cnt;
    reg filt_out;
    reg rx_line;
    reg rx_prev;
    reg [`IRB_CNT_W-1:0] tx_cnt;
    reg tx_bit;
    reg [`IRB_CNT_W-1:0] rx_cnt;
    reg rx_window;
    reg pulse_seen;
    reg rx_active;
    wire rx_fall;
    wire tx_allowed;
    reg next_tx_out;
    reg [`IRB_CNT_W-1:0] next_tx_cnt;
    reg next_tx_bit;
    reg [`IRB_FILT_W-1:0] next_filt_cnt;
    reg next_filt_out;
    reg next_rx_line;
    reg [`IRB_CNT_W-1:0] next_rx_cnt;
    reg next_rx_window;
    reg next_pulse_seen;
    reg next_rx_active;
    reg next_uart_rxd;

    // Reset release through two flops
    always @(posedge I_MCLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    assign rst_n = rst_sync;

    // Three-flop synchroniser on the receive pin
    always @(posedge I_MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_s1 <= 1'b0;
            rx_s2 <= 1'b0;
            rx_s3 <= 1'b0;
        end
        else
        begin
            rx_s1 <= I_MODULATED_RX_IN;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
        end
    end

    // Change accepted once the last two stages agree
    // A level seen by one stage only is dropped
    always @(posedge I_MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_clean <= 1'b0;
        end
        else if (rx_s2 == rx_s3)
        begin
            rx_clean <= rx_s3;
        end
    end

    // Saturating noise filter; output flips only at the rails
    always @*
    begin
        next_filt_cnt = filt_cnt;
        next_filt_out = filt_out;
        if (rx_clean && filt_cnt != `IRB_FILT_MAX)
        begin
            next_filt_cnt = filt_cnt + 1'b1;
        end
        else if (!rx_clean && filt_cnt != `IRB_FILT_ZERO)
        begin
            next_filt_cnt = filt_cnt - 1'b1;
        end
        if (filt_cnt == `IRB_FILT_MAX)
        begin
            next_filt_out = 1'b1;
        end
        else if (filt_cnt == `IRB_FILT_ZERO)
        begin
            next_filt_out = 1'b0;
        end
    end

    always @(posedge I_MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            filt_cnt <= `IRB_FILT_ZERO;
            filt_out <= 1'b0;
        end
        else
        begin
            filt_cnt <= next_filt_cnt;
            filt_out <= next_filt_out;
        end
    end

    // Filter in or out of the receive path
    always @*
    begin
        next_rx_line = rx_clean;
        if (I_NOISE_FILTER_SELECT)
        begin
            next_rx_line = filt_out;
        end
    end

    always @(posedge I_MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_line <= 1'b0;
            rx_prev <= 1'b0;
        end
        else
        begin
            rx_line <= next_rx_line;
            rx_prev <= rx_line;
        end
    end

    // Transceiver pulse is active high; its trailing edge marks a pulse
    assign rx_fall = rx_prev && !rx_line;
    assign tx_allowed = I_ENABLE && !rx_active;

    // Transmit modulator; a bit is taken at count 0 of each period
    always @*
    begin
        next_tx_cnt = tx_cnt;
        next_tx_bit = tx_bit;
        if (!tx_allowed)
        begin
            // Receiving or off: modulator held idle
            next_tx_cnt = `IRB_CNT_ZERO;
            next_tx_bit = 1'b1;
        end
        else if (I_BAUD_TICK)
        begin
            if (tx_cnt == `IRB_CNT_LAST)
            begin
                // Reload at wrap so the new bit is ready at count 0
                next_tx_cnt = `IRB_CNT_ZERO;
                next_tx_bit = I_UART_TXD;
            end
            else
            begin
                next_tx_cnt = tx_cnt + 1'b1;
            end
            if (tx_cnt == `IRB_CNT_ZERO)
            begin
                next_tx_bit = I_UART_TXD;
            end
        end
    end

    always @(posedge I_MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_cnt <= `IRB_CNT_ZERO;
            tx_bit <= 1'b1;
        end
        else
        begin
            tx_cnt <= next_tx_cnt;
            tx_bit <= next_tx_bit;
        end
    end

    always @*
    begin
        next_tx_out = 1'b0;
        if (tx_allowed && !tx_bit && tx_cnt >= `IRB_PULSE_START && tx_cnt < `IRB_PULSE_END)
        begin
            next_tx_out = 1'b1;
        end
    end

    // Receive decoder, next values
    always @*
    begin
        next_rx_cnt = rx_cnt;
        next_rx_window = rx_window;
        next_pulse_seen = pulse_seen;
        next_rx_active = rx_active;
        next_uart_rxd = O_UART_RXD;
        if (!I_ENABLE)
        begin
            // Endec off: UART sees the conditioned pin
            next_rx_cnt = `IRB_CNT_ZERO;
            next_rx_window = 1'b1;
            next_pulse_seen = 1'b0;
            next_rx_active = 1'b0;
            next_uart_rxd = rx_clean;
        end
        else if (I_UART_TX_BUSY)
        begin
            // Half duplex: echoes of our own pulses are ignored
            next_rx_cnt = `IRB_CNT_ZERO;
            next_rx_window = 1'b1;
            next_pulse_seen = 1'b0;
            next_rx_active = 1'b0;
            next_uart_rxd = 1'b1;
        end
        else if (rx_fall && rx_window)
        begin
            // Trailing pulse edge restarts bit timing; beats a tick
            next_rx_cnt = `IRB_CNT_ZERO;
            next_rx_window = 1'b0;
            next_pulse_seen = 1'b1;
            next_rx_active = 1'b1;
        end
        else if (I_BAUD_TICK)
        begin
            if (rx_cnt == `IRB_CNT_LAST)
            begin
                next_rx_cnt = `IRB_CNT_ZERO;
                if (!pulse_seen)
                begin
                    // A quiet period ends the reception
                    next_rx_active = 1'b0;
                end
            end
            else
            begin
                next_rx_cnt = rx_cnt + 1'b1;
            end
            if (rx_cnt == `IRB_UPDATE_CNT)
            begin
                next_uart_rxd = !pulse_seen;
                next_pulse_seen = 1'b0;
            end
            if (rx_cnt == `IRB_WINDOW_CNT)
            begin
                next_rx_window = 1'b1;
            end
        end
    end

    always @(posedge I_MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_cnt <= `IRB_CNT_ZERO;
            rx_window <= 1'b1;
            pulse_seen <= 1'b0;
            rx_active <= 1'b0;
            O_UART_RXD <= 1'b1;
        end
        else
        begin
            rx_cnt <= next_rx_cnt;
            rx_window <= next_rx_window;
            pulse_seen <= next_pulse_seen;
            rx_active <= next_rx_active;
            O_UART_RXD <= next_uart_rxd;
        end
    end

    // Transmit pin: modulated when enabled, plain UART data otherwise
    always @(posedge I_MCLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            O_MODULATED_TX_OUT <= 1'b0;
        end
        else
        begin
            O_MODULATED_TX_OUT <= I_ENABLE ? next_tx_out : I_UART_TXD;
        end
    end

endmodule

// file: irb_ir_xcvr.sv
// Infrared transceiver model driving the receive pin.
// Assumes the bench calls send_bit back to back.
`timescale 1ns/100ps
module irb_ir_xcvr(
    input wire i_clk,
    input wire i_tick,
    output reg o_rx
);
    integer k;
    initial o_rx = 1'b0;
    task send_bit(input b);
        for (k = 0; k < 16; k = k + 1)
            @(posedge i_clk iff i_tick) o_rx <= !b && k > 6 && k < 10;
    endtask
endmodule

// file: irb_endec_monitor.sv
// Port checker for irb_endec.
// Assumes a steady baud tick.
`timescale 1ns/100ps
module irb_endec_monitor(
    input wire I_MCLK,
    input wire I_RESETN,
    input wire I_ENABLE,
    input wire I_UART_TXD,
    input wire I_UART_TX_BUSY,
    input wire I_MODULATED_RX_IN,
    input wire O_MODULATED_TX_OUT,
    input wire O_UART_RXD
);
    wire t = O_MODULATED_TX_OUT;
    wire r = O_UART_RXD;
    wire x = I_MODULATED_RX_IN;
    wire e = I_ENABLE;
    wire d = I_UART_TXD;
    wire b = I_UART_TX_BUSY;
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);
    tx_pass_a: assert property (!e && $past(I_RESETN, 3) |=> t == $past(d)) else $error("tx");
    rx_pass_a: assert property (!e && $past(I_RESETN, 3) |-> ##[0:8] r == x) else $error("rx");
    pulse_len_a: assert property (e && $rose(t) |-> t [*6] ##1 !t) else $error("len");
    pulse_gap_a: assert property (e && $fell(t) |=> !t [*8]) else $error("gap");
    pulse_src_a: assert property (e && $rose(t) |-> !$past(d, 12)) else $error("src");
    rx_lag_a: assert property (e && !b && $fell(x) |-> ##[16:40] !r) else $error("lag");
    rx_busy_a: assert property (e && $fell(r) |-> !$past(b)) else $error("busy");
    rx_low_a: assert property (e && $fell(r) |=> !r [*8]) else $error("low");
endmodule
bind irb_endec irb_endec_monitor mon_u(
    .I_MCLK(I_MCLK),
    .I_RESETN(I_RESETN),
    .I_ENABLE(I_ENABLE),
    .I_UART_TXD(I_UART_TXD),
    .I_UART_TX_BUSY(I_UART_TX_BUSY),
    .I_MODULATED_RX_IN(I_MODULATED_RX_IN),
    .O_MODULATED_TX_OUT(O_MODULATED_TX_OUT),
    .O_UART_RXD(O_UART_RXD)
);

// file: tb_irb_endec.sv
// Bench for irb_endec with a transceiver model.
// Assumes a tick every other clock.
`timescale 1ns/100ps
module tb_irb_endec;
    reg I_MCLK = 1'b0, I_RESETN = 1'b0, I_ENABLE = 1'b1, I_BAUD_TICK = 1'b0;
    reg I_NOISE_FILTER_SELECT = 1'b0, I_UART_TXD = 1'b1, I_UART_TX_BUSY = 1'b1, go = 1'b0, p;
    wire I_MODULATED_RX_IN, O_MODULATED_TX_OUT, O_UART_RXD;
    integer tk = 0, n_errors = 0, n_compared = 0, i;
    irb_endec dut_u(
        .I_MCLK(I_MCLK),
        .I_RESETN(I_RESETN),
        .I_ENABLE(I_ENABLE),
        .I_BAUD_TICK(I_BAUD_TICK),
        .I_NOISE_FILTER_SELECT(I_NOISE_FILTER_SELECT),
        .I_UART_TXD(I_UART_TXD),
        .I_UART_TX_BUSY(I_UART_TX_BUSY),
        .I_MODULATED_RX_IN(I_MODULATED_RX_IN),
        .O_MODULATED_TX_OUT(O_MODULATED_TX_OUT),
        .O_UART_RXD(O_UART_RXD)
    );
    irb_ir_xcvr ir_u(.i_clk(I_MCLK), .i_tick(I_BAUD_TICK), .o_rx(I_MODULATED_RX_IN));
    always #20 I_MCLK = ~I_MCLK;
    always @(posedge I_MCLK)
    begin
        I_BAUD_TICK <= go && !I_BAUD_TICK;
        tk <= tk + I_BAUD_TICK;
    end
    task chk(input g, input e);
        n_compared = n_compared + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("ERROR %0t %h %h", $time, g, e);
        end
    endtask
    task till(integer m);
        do @(posedge I_MCLK); while (tk % 16 != m);
    endtask
    task tx_bits(input [7:0] d);
        for (i = 0; i < 8; i = i + 1)
        begin
            till(8);
            I_UART_TXD <= d[i];
            till(0);
            till(7);
            chk(O_MODULATED_TX_OUT, 1'b0);
            till(8);
            chk(O_MODULATED_TX_OUT, !d[i]);
            till(10);
            chk(O_MODULATED_TX_OUT, !d[i]);
            till(11);
            chk(O_MODULATED_TX_OUT, 1'b0);
        end
        $display("tx done");
    endtask
    task off_check;
        I_ENABLE <= 1'b0;
        repeat (8) @(posedge I_MCLK);
        chk(O_UART_RXD, 1'b0);
        chk(O_MODULATED_TX_OUT, 1'b1);
        I_UART_TXD <= 1'b0;
        repeat (3) @(posedge I_MCLK);
        chk(O_MODULATED_TX_OUT, 1'b0);
        $display("off done");
    endtask
    task rx_bits(input f, input b, input [6:0] d);
        p = 1'b1;
        I_NOISE_FILTER_SELECT <= f;
        I_UART_TX_BUSY <= b;
        till(15);
        for (i = 0; i < 7; i = i + 1)
        fork
            ir_u.send_bit(d[i]);
            begin
                till(10);
                chk(O_UART_RXD, b | p);
                p = d[i];
            end
        join
        $display("rx done");
    endtask
    task finish_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        // Tests need about 50 us; allow several times that
        #400000 n_errors = n_errors + 1;
        finish_test;
    end
    initial
    begin
        repeat (16) @(posedge I_MCLK);
        I_RESETN <= 1'b1;
        repeat (4) @(posedge I_MCLK);
        I_ENABLE <= 1'b1;
        go <= 1'b1;
        tx_bits(8'hb5);
        rx_bits(0, 0, 7'h4c);
        rx_bits(1, 0, 7'h4c);
        rx_bits(0, 1, 7'h4c);
        off_check;
        finish_test;
    end
endmodule
